// ==== hw/anr_pkg.sv ====
package anr_pkg;
   // Register indices on the management port
   localparam logic [4:0]  ADDR_NP_TX    = 5'h07;
   localparam logic [4:0]  ADDR_NP_RX    = 5'h08;
   localparam logic [4:0]  ADDR_MS_CTRL  = 5'h09;
   // Field positions
   localparam int          NP_BIT        = 15;
   localparam int          ACK_BIT       = 14;
   localparam int          MP_BIT        = 13;
   localparam int          ACK2_BIT      = 12;
   localparam int          TOG_BIT       = 11;
   localparam int          TM_LSB        = 13;
   localparam int          MAN_EN_BIT    = 12;
   localparam int          MAN_VAL_BIT   = 11;
   localparam int          PORT_BIT      = 10;
   localparam int          FD_BIT        = 9;
   localparam int          HD_BIT        = 8;
   // Reset values
   localparam logic [10:0] TX_CODE_RST   = 11'h001;
   localparam logic [2:0]  TM_RST        = 3'h0;
   localparam logic [4:0]  MS_ADV_RST    = 5'h0e;  // En 0, val 1, port 1, fd 1, hd 0
   localparam logic [1:0]  MDIX_AUTO     = 2'h3;
   typedef enum logic [2:0] {
      TM_NORMAL, TM_WAVEFORM, TM_JIT_MASTER, TM_JIT_SLAVE, TM_OTHER
   } anr_test_t;
endpackage

// ==== hw/anr_field.sv ====
`timescale 1ns/1ps
`default_nettype none
// Resettable field with separate hardware and software reset values
module anr_field #(
   parameter int            W       = 1,
   parameter logic [W-1:0]  HW_RST  = '0,
   parameter logic [W-1:0]  SW_RST  = '0,
   parameter bit            RETAIN  = 1'b0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         sw_rst,
   // Write port
   input  wire logic         we,
   input  wire logic [W-1:0] wdata,
   output logic      [W-1:0] q
);
   logic [W-1:0] q_next;

   // Retained fields ignore the software reset
   assign q_next = (sw_rst && !RETAIN) ? SW_RST : (we ? wdata : q);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= HW_RST;
      end else begin
         q <= q_next;
      end
   end
endmodule
`default_nettype wire

// ==== hw/anr_regs.sv ====
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module anr_regs
   import anr_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        sw_rst,
   // Register port
   input  wire logic [4:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   // Auto-negotiation engine
   input  wire logic        an_restart,
   input  wire logic        link_down,
   input  wire logic        page_rx,
   input  wire logic [15:0] page_rx_word,
   input  wire logic        page_tx,
   input  wire logic [1:0]  mdix_mode,
   // Outputs to the engine and transmitter
   output logic      [15:0] tx_page_word,
   output logic      [2:0]  test_mode,
   output logic             ms_manual,
   output logic             ms_value,
   output logic             ms_port,
   output logic             adv_fd,
   output logic             adv_hd,
   output logic             page_rx_flag
);
   // Software-visible storage
   logic        np_q;
   logic        mp_q;
   logic        ack2_q;
   logic [10:0] code_q;
   logic [2:0]  tm_q;
   logic [4:0]  ms_q;
   logic        tog_reg;
   logic [15:0] rx_reg;
   logic        flag_reg;
   logic        flag_next;
   logic [15:0] rdata_next;
   logic [15:0] tx_word;
   logic [15:0] ms_word;
   logic        apply;
   logic        tm_allowed;
   logic [2:0]  tm_eff;
   logic        we_tx;
   logic        we_ms;
   logic        rd_rx;

   assign we_tx = wr && (addr == ADDR_NP_TX);
   assign we_ms = wr && (addr == ADDR_MS_CTRL);
   assign rd_rx = rd && (addr == ADDR_NP_RX);

   // Transmit page fields
   anr_field #(.W(1), .HW_RST(1'b0), .SW_RST(1'b0)) u_np (
      .clk(clk), .rstn(rstn), .sw_rst(sw_rst), .we(we_tx),
      .wdata(wdata[NP_BIT]), .q(np_q));
   anr_field #(.W(1), .HW_RST(1'b1), .SW_RST(1'b1)) u_mp (
      .clk(clk), .rstn(rstn), .sw_rst(sw_rst), .we(we_tx),
      .wdata(wdata[MP_BIT]), .q(mp_q));
   anr_field #(.W(1), .HW_RST(1'b0), .SW_RST(1'b0)) u_ack2 (
      .clk(clk), .rstn(rstn), .sw_rst(sw_rst), .we(we_tx),
      .wdata(wdata[ACK2_BIT]), .q(ack2_q));
   anr_field #(.W(11), .HW_RST(TX_CODE_RST), .SW_RST(TX_CODE_RST)) u_code (
      .clk(clk), .rstn(rstn), .sw_rst(sw_rst), .we(we_tx),
      .wdata(wdata[10:0]), .q(code_q));
   // Master-slave control fields
   anr_field #(.W(3), .HW_RST(TM_RST), .SW_RST(TM_RST)) u_tm (
      .clk(clk), .rstn(rstn), .sw_rst(sw_rst), .we(we_ms),
      .wdata(wdata[15:13]), .q(tm_q));
   anr_field #(.W(5), .HW_RST(MS_ADV_RST), .SW_RST(MS_ADV_RST), .RETAIN(1'b1)) u_ms (
      .clk(clk), .rstn(rstn), .sw_rst(sw_rst), .we(we_ms),
      .wdata(wdata[12:8]), .q(ms_q));

   // Toggle flips with every page sent, so it always reads as the inverse of
   // the value that went out with the previous page; it reads zero after reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tog_reg <= 1'b0;
      end else if (sw_rst) begin
         tog_reg <= 1'b0;
      end else if (page_tx) begin
         tog_reg <= ~tog_reg;
      end
   end

   // Received page is captured with the flag and held until the next one or a software reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_reg <= 16'h0000;
      end else if (sw_rst) begin
         rx_reg <= 16'h0000;
      end else if (page_rx) begin
         rx_reg <= page_rx_word;
      end
   end

   // Latching-high flag; a new page in the read cycle wins over the clear
   assign flag_next = page_rx ? 1'b1 : (rd_rx ? 1'b0 : flag_reg);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flag_reg <= 1'b0;
      end else if (sw_rst) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   // Advertisement applies only on restart or link loss
   assign apply = an_restart || link_down;
   // Test modes need crossover forced manual first
   assign tm_allowed = (mdix_mode != MDIX_AUTO);
   assign tm_eff     = tm_allowed ? tm_q : TM_RST;

   // Outputs held in flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ms_manual <= MS_ADV_RST[4];
         ms_value  <= MS_ADV_RST[3];
         ms_port   <= MS_ADV_RST[2];
         adv_fd    <= MS_ADV_RST[1];
         adv_hd    <= MS_ADV_RST[0];
      end else if (apply) begin
         ms_manual <= ms_q[4];
         ms_value  <= ms_q[3];
         ms_port   <= ms_q[2];
         adv_fd    <= ms_q[1];
         adv_hd    <= ms_q[0];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         test_mode    <= TM_RST;
         tx_page_word <= 16'h0000;
         page_rx_flag <= 1'b0;
         rdata        <= 16'h0000;
      end else begin
         test_mode    <= tm_eff;
         tx_page_word <= tx_word;
         page_rx_flag <= flag_next;
         rdata        <= rdata_next;
      end
   end

   // Read words; bit 14 of transmit and bits 7:0 of control read zero
   assign tx_word = {np_q, 1'b0, mp_q, ack2_q, tog_reg, code_q};
   assign ms_word = {tm_q, ms_q, 8'h00};
   assign rdata_next = !rd ? 16'h0000 :
                       (addr == ADDR_NP_TX)   ? tx_word :
                       (addr == ADDR_NP_RX)   ? rx_reg :
                       (addr == ADDR_MS_CTRL) ? ms_word : 16'h0000;

   // Checks
   chk_tx_bit14_zero: assert property (@(posedge clk) disable iff (!rstn)
      rd && addr == ADDR_NP_TX |=> rdata[ACK_BIT] == 1'b0)
      else $error("transmit bit 14 not zero");
   chk_ms_low_zero: assert property (@(posedge clk) disable iff (!rstn)
      rd && addr == ADDR_MS_CTRL |=> rdata[7:0] == 8'h00)
      else $error("control low byte not zero");
   chk_rx_capture: assert property (@(posedge clk) disable iff (!rstn)
      page_rx && !sw_rst ##1 rd && addr == ADDR_NP_RX && !page_rx && !sw_rst
      |=> rdata == $past(page_rx_word, 2))
      else $error("received page not captured");
   chk_flag_set: assert property (@(posedge clk) disable iff (!rstn)
      page_rx && !sw_rst |=> page_rx_flag)
      else $error("page flag not set");
   chk_tm_gate: assert property (@(posedge clk) disable iff (!rstn)
      mdix_mode == MDIX_AUTO |=> test_mode == TM_RST)
      else $error("test mode with auto crossover");
   chk_adv_hold: assert property (@(posedge clk) disable iff (!rstn)
      !apply |=> $stable(adv_fd) && $stable(ms_manual))
      else $error("advertisement changed without restart");
   chk_adv_apply: assert property (@(posedge clk) disable iff (!rstn)
      link_down |=> adv_hd == $past(ms_q[0]))
      else $error("link down did not apply settings");
   chk_toggle_inv: assert property (@(posedge clk) disable iff (!rstn)
      page_tx && !sw_rst |=> ##1 tx_page_word[TOG_BIT] != $past(tx_page_word[TOG_BIT]))
      else $error("toggle not inverse");
   // Writable transmit fields take the written value
   chk_np_write: assert property (@(posedge clk) disable iff (!rstn)
      we_tx && !sw_rst |=> np_q == $past(wdata[NP_BIT]))
      else $error("next page bit not written");
   chk_mp_write: assert property (@(posedge clk) disable iff (!rstn)
      we_tx && !sw_rst |=> mp_q == $past(wdata[MP_BIT]))
      else $error("message page bit not written");
   chk_ack2_write: assert property (@(posedge clk) disable iff (!rstn)
      we_tx && !sw_rst |=> ack2_q == $past(wdata[ACK2_BIT]))
      else $error("comply bit not written");
   chk_code_write: assert property (@(posedge clk) disable iff (!rstn)
      we_tx && !sw_rst |=> code_q == $past(wdata[10:0]))
      else $error("code field not written");
   // Software reset brings the transmit word back to its reset value
   chk_swrst_tx: assert property (@(posedge clk) disable iff (!rstn)
      sw_rst |=> tx_word == {4'h2, 1'b0, TX_CODE_RST})
      else $error("transmit word not reset");
   // Received page ignores writes and keeps its value between pages
   chk_rx_readonly: assert property (@(posedge clk) disable iff (!rstn)
      wr && addr == ADDR_NP_RX && !page_rx && !sw_rst |=> $stable(rx_reg))
      else $error("received page written");
   chk_rx_ack: assert property (@(posedge clk) disable iff (!rstn)
      page_rx && !sw_rst |=> rx_reg[ACK_BIT] == $past(page_rx_word[ACK_BIT]))
      else $error("partner acknowledge lost");
   chk_rx_hold: assert property (@(posedge clk) disable iff (!rstn)
      !page_rx && !sw_rst |=> $stable(rx_reg))
      else $error("received page changed");
   chk_flag_hold: assert property (@(posedge clk) disable iff (!rstn)
      !page_rx && !rd_rx && !sw_rst |=> $stable(page_rx_flag))
      else $error("page flag changed on its own");
   // Control register fields
   chk_tm_write: assert property (@(posedge clk) disable iff (!rstn)
      we_ms && !sw_rst |=> tm_q == $past(wdata[15:13]))
      else $error("test mode not written");
   chk_ms_retain: assert property (@(posedge clk) disable iff (!rstn)
      sw_rst && !we_ms |=> $stable(ms_q))
      else $error("retained bits lost on software reset");
   chk_manual_apply: assert property (@(posedge clk) disable iff (!rstn)
      apply |=> ms_manual == $past(ms_q[4]) && ms_value == $past(ms_q[3]))
      else $error("manual setting not applied");
   chk_port_apply: assert property (@(posedge clk) disable iff (!rstn)
      apply |=> ms_port == $past(ms_q[2]))
      else $error("port type not applied");
   chk_fd_apply: assert property (@(posedge clk) disable iff (!rstn)
      apply |=> adv_fd == $past(ms_q[1]))
      else $error("full duplex not applied");
   // Read data stand only in the cycle after a read strobe
   chk_rdata_idle: assert property (@(posedge clk) disable iff (!rstn)
      !rd |=> rdata == 16'h0000)
      else $error("read data outside read");
   cov_page_rx: cover property (@(posedge clk) disable iff (!rstn) page_rx ##1 rd_rx);
   cov_restart: cover property (@(posedge clk) disable iff (!rstn) we_ms ##[1:4] an_restart);
   cov_test_on: cover property (@(posedge clk) disable iff (!rstn) test_mode != TM_RST);
endmodule
`default_nettype wire

// ==== verification/anr_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
// Far-side link partner: hands one received page to the engine port per send
module anr_partner (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Bench command
   input  wire logic        send,
   input  wire logic [15:0] word,
   // Engine side
   output logic             page_rx,
   output logic      [15:0] page_rx_word
);
   // Outside a delivery the word flips every cycle, so a stale value matches only every other cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         page_rx      <= 1'b0;
         page_rx_word <= 16'hffff;
      end else begin
         page_rx      <= send;
         page_rx_word <= send ? word : ~page_rx_word;
      end
   end
endmodule
`default_nettype wire

// ==== verification/autoneg_nextpage_master_slave_regs_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module autoneg_nextpage_master_slave_regs_bench;
   import anr_pkg::*;
   logic        clk, rstn, sw_rst, wr, rd, an_restart, link_down, page_tx, send, flag;
   logic        page_rx, ms_manual, ms_value, ms_port, adv_fd, adv_hd;
   logic [4:0]  addr;
   logic [1:0]  mdix_mode;
   logic [2:0]  test_mode;
   logic [15:0] wdata, rdata, page_rx_word, tx_page_word, pword, v;
   int          errors, checks_done, cycles;
   wire  [15:0] outs = {8'h00, test_mode, ms_manual, ms_value, ms_port, adv_fd, adv_hd};

   anr_regs DUT (.clk(clk), .rstn(rstn), .sw_rst(sw_rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .an_restart(an_restart), .link_down(link_down),
      .page_rx(page_rx), .page_rx_word(page_rx_word), .page_tx(page_tx),
      .mdix_mode(mdix_mode), .tx_page_word(tx_page_word), .test_mode(test_mode),
      .ms_manual(ms_manual), .ms_value(ms_value), .ms_port(ms_port), .adv_fd(adv_fd),
      .adv_hd(adv_hd), .page_rx_flag(flag));
   anr_partner peer (.clk(clk), .rstn(rstn), .send(send), .word(pword),
      .page_rx(page_rx), .page_rx_word(page_rx_word));

   // 250 MHz clock; the ceiling is far above the roughly 72 cycles needed
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         wrap_up();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One-cycle strobes, launched right after an edge
   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [4:0] a);
      @(posedge clk);
      rd <= 1'b1; addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic t_reset();
      rd_reg(ADDR_NP_TX);   check(v, 16'h2001);
      rd_reg(ADDR_NP_RX);   check(v, 16'h0000);
      rd_reg(ADDR_MS_CTRL); check(v, 16'h0e00);
      rd_reg(5'h1f);        check(v, 16'h0000);
      check(outs, 16'h000e);
      $display("test reset done");
   endtask
   task automatic t_tx();
      wr_reg(ADDR_NP_TX, 16'hffff);
      rd_reg(ADDR_NP_TX); check(v, 16'hb7ff);
      check(tx_page_word, 16'hb7ff);
      @(posedge clk) page_tx <= 1'b1;
      @(posedge clk) page_tx <= 1'b0;
      rd_reg(ADDR_NP_TX); check(v, 16'hbfff);
      check(tx_page_word, 16'hbfff);
      $display("test transmit page done");
   endtask
   task automatic t_rx();
      wr_reg(ADDR_NP_RX, 16'hffff);
      @(posedge clk) begin send <= 1'b1; pword <= 16'h5a5a; end
      @(posedge clk) send <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check({15'h0, flag}, 16'h0001);
      rd_reg(ADDR_NP_RX); check(v, 16'h5a5a);
      check({15'h0, flag}, 16'h0000);
      $display("test receive page done");
   endtask
   task automatic t_ms();
      wr_reg(ADDR_MS_CTRL, 16'h3f00);
      #1 check(outs, 16'h000e);
      rd_reg(ADDR_MS_CTRL); check(v, 16'h3f00);
      @(posedge clk) an_restart <= 1'b1;
      @(posedge clk) an_restart <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check(outs, 16'h001f);
      @(posedge clk) mdix_mode <= 2'h0;
      for (int k = 0; k < 4; k++) begin
         wr_reg(ADDR_MS_CTRL, {k[2:0], 13'h1f00});
         repeat (2) @(posedge clk);
         #1 check({13'h0, test_mode}, {13'h0, k[2:0]});
      end
      @(posedge clk) mdix_mode <= MDIX_AUTO;
      repeat (2) @(posedge clk);
      #1 check({13'h0, test_mode}, 16'h0000);
      wr_reg(ADDR_MS_CTRL, 16'h0000);
      @(posedge clk) link_down <= 1'b1;
      @(posedge clk) link_down <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check(outs, 16'h0000);
      wr_reg(ADDR_MS_CTRL, 16'h1f00);
      wr_reg(ADDR_NP_TX, 16'hffff);
      @(posedge clk) sw_rst <= 1'b1;
      @(posedge clk) sw_rst <= 1'b0;
      rd_reg(ADDR_NP_TX);   check(v, 16'h2001);
      rd_reg(ADDR_MS_CTRL); check(v, 16'h1f00);
      $display("test master-slave done");
   endtask

   initial begin
      clk = 0; rstn = 0; sw_rst = 0; wr = 0; rd = 0; addr = 0; wdata = 0;
      an_restart = 0; link_down = 0; page_tx = 0; send = 0; pword = 0;
      mdix_mode = MDIX_AUTO; errors = 0; checks_done = 0; cycles = 0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_tx();
      t_rx();
      t_ms();
      wrap_up();
   end
endmodule
`default_nettype wire
